// ---- design/i2c_slave_defines.svh ----
// constants for the two-wire slave, watchdog and reset sequencer
// assumes a 10 MHz system clock; all times are converted from it
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH
`define CLK_KHZ 10000
`define TMR_W 25
`define BUSY_W 16
`define WDT_OFF 2'h3
`define WDT_SEL_250 2'h2
`define WDT_SEL_750 2'h1
`define WDT_SEL_1750 2'h0
`define WDT_250_MS 250
`define WDT_750_MS 750
`define WDT_1750_MS 1750
`define RST_TMO_MS 250
`define WR_CYC_MS 5
`define ID_ARRAY 4'ha
`define ID_CCR 4'hd
`define DEV_SEL 3'h7
`define ARR_MASK 4'hf
`define CCR_MASK 4'h7
`define ADDR_RST 16'h0000
`endif

// ---- design/i2c_slave_pkg.sv ----
// types shared by the slave, watchdog and reset sequencer
// assumes the defines header is on the include path
`include "i2c_slave_defines.svh"
package i2c_slave_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK = 3'b010,
    ST_TX = 3'b011,
    ST_RXACK = 3'b100
  } i2c_st_t;
  typedef struct packed {
    logic scl;
    logic sda;
    logic low_voltage_reset;
    logic bat;
    logic prot;
    logic [1:0] wdSel;
  } pins_t;
  typedef struct packed {
    pins_t syncA;
    pins_t syncB;
    logic prevScl;
    logic prevSda;
    i2c_st_t st;
    logic [3:0] bitCnt;
    logic [7:0] sh;
    logic [1:0] byteIdx;
    logic rw;
    logic clock_control_space;
    logic ackData;
    logic dataSeen;
    logic [15:0] addr;
    logic [15:0][7:0] pgData;
    logic [15:0] pgVld;
    logic busy;
    logic [`BUSY_W-1:0] busyCnt;
    logic [4:0] wrIdx;
    logic sdaOe;
    logic startP;
  } slv_t;
  typedef struct packed {
    logic [`TMR_W-1:0] cnt;
    logic exp;
  } wdt_t;
  typedef struct packed {
    logic [`TMR_W-1:0] cnt;
    logic latchBat;
    logic outN;
  } rstseq_t;
endpackage

// ---- design/watchdog_timer.sv ----
// watchdog counter reloaded by bus START conditions
// assumes all inputs are already in the clk_sys domain
`timescale 1ns/10ps
module watchdog_timer
  import i2c_slave_pkg::*;
#(
  parameter int C250 = `WDT_250_MS * `CLK_KHZ,
  parameter int C750 = `WDT_750_MS * `CLK_KHZ,
  parameter int C1750 = `WDT_1750_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // control
  input wire logic [1:0] periodSel,
  input wire logic startSeen,
  input wire logic batteryMode,
  input wire logic rstActive,
  // event
  output logic expire
);
  wdt_t s;
  wdt_t n;
  logic [`TMR_W-1:0] full;

  always_comb begin
    unique case (periodSel)
      `WDT_SEL_250: full = `TMR_W'(C250 - 1);
      `WDT_SEL_750: full = `TMR_W'(C750 - 1);
      `WDT_SEL_1750: full = `TMR_W'(C1750 - 1);
      `WDT_OFF: full = '0;
    endcase
  end

  always_comb begin
    n = s;
    n.exp = 1'b0;
    if (periodSel == `WDT_OFF || batteryMode || rstActive) begin
      n.cnt = full;
    end else if (startSeen) begin
      n.cnt = full;
    end else if (s.cnt == '0) begin
      n.exp = 1'b1;
      n.cnt = full;
    end else begin
      n.cnt = s.cnt - `TMR_W'(1);
    end
    if (!nrst) begin
      n = '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= n;
  end

  assign expire = s.exp;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_off;
    periodSel == `WDT_OFF |=> !s.exp;
  endproperty
  a_off: assert property (p_off)
    else $error("watchdog fired while switched off");
  property p_reload;
    startSeen && !rstActive && !batteryMode && periodSel != `WDT_OFF
      |=> s.cnt == $past(full);
  endproperty
  a_reload: assert property (p_reload)
    else $error("start did not reload the watchdog");
  property p_exp;
    s.exp |-> $past(s.cnt) == '0;
  endproperty
  a_exp: assert property (p_exp)
    else $error("watchdog fired before count ran out");
  property p_hold;
    rstActive |=> !s.exp;
  endproperty
  a_hold: assert property (p_hold)
    else $error("watchdog ran during reset timeout");
  property p_bat;
    batteryMode |=> !s.exp;
  endproperty
  a_bat: assert property (p_bat)
    else $error("watchdog fired in battery mode");
  c_exp: cover property (s.exp);
endmodule

// ---- design/reset_sequencer.sv ----
// reset output from supply-low, battery dip and watchdog expiry
// assumes all inputs are already in the clk_sys domain
`timescale 1ns/10ps
module reset_sequencer
  import i2c_slave_pkg::*;
#(
  parameter int RST_CYC = `RST_TMO_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // causes
  input wire logic lowVoltage,
  input wire logic batteryMode,
  input wire logic wdtExpire,
  // reset output
  output logic rstOutN
);
  localparam logic [`TMR_W-1:0] FULL = `TMR_W'(RST_CYC - 1);
  rstseq_t s;
  rstseq_t n;

  always_comb begin
    n = s;
    if (lowVoltage) begin
      n.outN = 1'b0;
      n.cnt = FULL;
      if (batteryMode) begin
        n.latchBat = 1'b1;
      end
    end else if (s.latchBat) begin
      n.outN = 1'b0;
      n.cnt = FULL;
      n.latchBat = batteryMode;
    end else if (wdtExpire && s.outN) begin
      n.outN = 1'b0;
      n.cnt = FULL;
    end else if (!s.outN) begin
      if (s.cnt == '0) begin
        n.outN = 1'b1;
      end else begin
        n.cnt = s.cnt - `TMR_W'(1);
      end
    end
    if (!nrst) begin
      n.cnt = FULL;
      n.latchBat = 1'b0;
      n.outN = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= n;
  end

  assign rstOutN = s.outN;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_lvr_low;
    lowVoltage |=> !s.outN;
  endproperty
  a_lvr_low: assert property (p_lvr_low)
    else $error("reset released while supply low");
  property p_bat_hold;
    s.latchBat && batteryMode |=> !s.outN;
  endproperty
  a_bat_hold: assert property (p_bat_hold)
    else $error("reset released while still on battery");
  property p_wd_pulse;
    wdtExpire && s.outN && !lowVoltage && !s.latchBat |=> !s.outN;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse)
    else $error("watchdog expiry did not assert reset");
  c_release: cover property ($rose(s.outN));
endmodule

// ---- design/i2c_slave_with_watchdog.sv ----
// two-wire slave with nonvolatile store, watchdog and reset output
// assumes bus and supply pins are asynchronous to clk_sys
`timescale 1ns/10ps
module i2c_slave_with_watchdog
  import i2c_slave_pkg::*;
#(
  parameter int ARR_BYTES = 512,
  parameter int CCR_BYTES = 64,
  parameter logic [15:0] PROT_BASE = 16'h0100,
  parameter int WDT_C250 = `WDT_250_MS * `CLK_KHZ,
  parameter int WDT_C750 = `WDT_750_MS * `CLK_KHZ,
  parameter int WDT_C1750 = `WDT_1750_MS * `CLK_KHZ,
  parameter int RST_CYC = `RST_TMO_MS * `CLK_KHZ,
  parameter int WR_CYC = `WR_CYC_MS * `CLK_KHZ
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // two-wire bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // supervisor pins
  input wire logic watchdogPeriodSelHi,
  input wire logic watchdogPeriodSelLo,
  input wire logic lowVoltageReset,
  input wire logic batteryMode,
  input wire logic blockProtect,
  output logic rstOutN
);
  localparam int ARR_AW = $clog2(ARR_BYTES);
  localparam int CCR_AW = $clog2(CCR_BYTES);
  localparam int MEM_N = ARR_BYTES + CCR_BYTES;
  localparam int MEM_AW = $clog2(MEM_N);

  if (ARR_BYTES < 16 || ARR_BYTES != 2 ** ARR_AW
      || ARR_BYTES > 65536) begin : g_bad_arr
    $error("array size must be a power of two from 16");
  end
  if (CCR_BYTES < 8 || CCR_BYTES != 2 ** CCR_AW
      || CCR_BYTES > 65536) begin : g_bad_ccr
    $error("control space must be a power of two from 8");
  end
  if (WR_CYC <= 16 || WR_CYC >= 2 ** `BUSY_W) begin : g_bad_wr
    $error("write cycle count out of range");
  end
  if (WDT_C250 < 2 || WDT_C750 < 2 || WDT_C1750 < 2
      || RST_CYC < 2 || WDT_C1750 >= 2 ** `TMR_W
      || RST_CYC >= 2 ** `TMR_W) begin : g_bad_tmr
    $error("timer count out of range");
  end

  slv_t s;
  slv_t n;
  pins_t pinsIn;
  logic sclS;
  logic sdaS;
  logic lvrS;
  logic batS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic match;
  logic prot;
  logic [3:0] pgMask;
  logic [3:0] pageIdx;
  logic [15:0] nextPg;
  logic [15:0] pageAddr;
  logic [7:0] rdData;
  logic wrEn;
  logic [MEM_AW-1:0] wrAddr;
  logic [7:0] wrData;
  logic wdtExpire;
  logic [7:0] mem [MEM_N];

  function automatic logic [MEM_AW-1:0] memIdx(
    input logic c,
    input logic [15:0] a
  );
    if (c) begin
      memIdx = MEM_AW'(ARR_BYTES) + MEM_AW'(a[CCR_AW-1:0]);
    end else begin
      memIdx = MEM_AW'(a[ARR_AW-1:0]);
    end
  endfunction

  assign pinsIn = '{
    scl: sclIn,
    sda: sdaIn,
    low_voltage_reset: lowVoltageReset,
    bat: batteryMode,
    prot: blockProtect,
    wdSel: {watchdogPeriodSelHi, watchdogPeriodSelLo}
  };

  // conditions from the second sync stage only
  assign sclS = s.syncB.scl;
  assign sdaS = s.syncB.sda;
  assign lvrS = s.syncB.low_voltage_reset;
  assign batS = s.syncB.bat;
  assign sclRise = sclS && !s.prevScl;
  assign sclFall = !sclS && s.prevScl;
  assign startDet = sclS && s.prevScl && !sdaS && s.prevSda;
  assign stopDet = sclS && s.prevScl && sdaS && !s.prevSda;

  // address decode and page arithmetic
  assign match = (s.sh[7:4] == `ID_ARRAY || s.sh[7:4] == `ID_CCR)
    && s.sh[3:1] == `DEV_SEL;
  assign prot = s.syncB.prot && !s.clock_control_space && s.addr >= PROT_BASE;
  assign pgMask = s.clock_control_space ? `CCR_MASK : `ARR_MASK;
  assign pageIdx = s.addr[3:0] & pgMask;
  assign nextPg = {s.addr[15:4],
    (s.addr[3:0] & ~pgMask) | ((s.addr[3:0] + 4'h1) & pgMask)};
  assign pageAddr = s.clock_control_space ? {s.addr[15:3], s.wrIdx[2:0]}
    : {s.addr[15:4], s.wrIdx[3:0]};
  assign rdData = mem[memIdx(s.clock_control_space, s.addr)];

  always_comb begin
    n = s;
    wrEn = 1'b0;
    wrAddr = '0;
    wrData = 8'h00;
    n.syncA = pinsIn;
    n.syncB = s.syncA;
    n.prevScl = sclS;
    n.prevSda = sdaS;
    n.startP = 1'b0;
    // internal write cycle: copy the page, then wait out the time
    if (s.busy) begin
      if (!s.wrIdx[4]) begin
        n.wrIdx = s.wrIdx + 5'h01;
        if (s.pgVld[s.wrIdx[3:0]]) begin
          wrEn = 1'b1;
          wrAddr = memIdx(s.clock_control_space, pageAddr);
          wrData = s.pgData[s.wrIdx[3:0]];
        end
      end
      n.busyCnt = s.busyCnt - `BUSY_W'(1);
      if (s.busyCnt == '0) begin
        n.busy = 1'b0;
      end
      if (lvrS && batS) begin
        n.busy = 1'b0;
      end
    end
    if (startDet) begin
      n.startP = 1'b1;
      n.sdaOe = 1'b0;
      n.st = ST_IDLE;
      if (!s.busy && !lvrS) begin
        n.st = ST_RX;
        n.bitCnt = 4'h0;
        n.byteIdx = 2'h0;
        n.pgVld = '0;
        n.dataSeen = 1'b0;
      end
    end else if (stopDet) begin
      n.st = ST_IDLE;
      n.sdaOe = 1'b0;
      n.dataSeen = 1'b0;
      if (!s.rw && s.dataSeen && !s.busy && !prot) begin
        n.busy = 1'b1;
        n.busyCnt = `BUSY_W'(WR_CYC - 1);
        n.wrIdx = 5'h00;
      end
    end else if (lvrS) begin
      n.st = ST_IDLE;
      n.sdaOe = 1'b0;
      n.dataSeen = 1'b0;
    end else begin
      unique case (s.st)
        ST_IDLE: begin
          n.st = ST_IDLE;
        end
        ST_RX: begin
          if (sclRise) begin
            n.sh = {s.sh[6:0], sdaS};
            n.bitCnt = s.bitCnt + 4'h1;
          end else if (sclFall && s.bitCnt == 4'h8) begin
            n.bitCnt = 4'h0;
            n.sdaOe = 1'b1;
            n.st = ST_ACK;
            n.ackData = 1'b0;
            if (s.byteIdx != 2'h3) begin
              n.byteIdx = s.byteIdx + 2'h1;
            end
            unique case (s.byteIdx)
              2'h0: begin
                if (match) begin
                  n.rw = s.sh[0];
                  n.clock_control_space = s.sh[7:4] == `ID_CCR;
                end else begin
                  n.sdaOe = 1'b0;
                  n.st = ST_IDLE;
                end
              end
              2'h1: begin
                n.addr[15:8] = s.sh;
              end
              2'h2: begin
                n.addr[7:0] = s.sh;
              end
              2'h3: begin
                n.pgData[pageIdx] = s.sh;
                n.pgVld[pageIdx] = 1'b1;
                n.ackData = 1'b1;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            n.sdaOe = 1'b0;
            n.st = ST_RX;
            if (s.ackData) begin
              n.dataSeen = 1'b1;
              n.addr = nextPg;
            end
            if (s.rw) begin
              n.st = ST_TX;
              n.sh = rdData;
              n.sdaOe = !rdData[7];
              n.bitCnt = 4'h0;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (s.bitCnt == 4'h7) begin
              n.sdaOe = 1'b0;
              n.st = ST_RXACK;
            end else begin
              n.sh = {s.sh[6:0], 1'b0};
              n.sdaOe = !s.sh[6];
              n.bitCnt = s.bitCnt + 4'h1;
            end
          end
        end
        ST_RXACK: begin
          if (sclRise) begin
            n.addr = s.addr + 16'h0001;
            n.ackData = 1'b0;
            n.st = sdaS ? ST_IDLE : ST_ACK;
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end
    if (!nrst) begin
      n = '0;
      n.addr = `ADDR_RST;
    end
  end

  always_ff @(posedge clk_sys) begin
    s <= n;
  end

  // nonvolatile store, contents undefined until written
  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  watchdog_timer #(
    .C250(WDT_C250),
    .C750(WDT_C750),
    .C1750(WDT_C1750)
  ) u_wdt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .periodSel(s.syncB.wdSel),
    .startSeen(s.startP),
    .batteryMode(batS),
    .rstActive(!rstOutN),
    .expire(wdtExpire)
  );

  reset_sequencer #(
    .RST_CYC(RST_CYC)
  ) u_rst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .lowVoltage(lvrS),
    .batteryMode(batS),
    .wdtExpire(wdtExpire),
    .rstOutN(rstOutN)
  );

  assign sdaOe = s.sdaOe;
  assign sdaOut = 1'b0;

  // checks
  logic quiet;
  logic byteDone;
  assign quiet = !startDet && !stopDet && !lvrS;
  assign byteDone = s.st == ST_RX && sclFall && s.bitCnt == 4'h8 && quiet;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_ack_good;
    byteDone && s.byteIdx == 2'h0 && match
      |=> s.sdaOe && s.st == ST_ACK;
  endproperty
  a_ack_good: assert property (p_ack_good)
    else $error("matching address not acknowledged");
  property p_nack_bad;
    byteDone && s.byteIdx == 2'h0 && !match
      |=> !s.sdaOe && s.st == ST_IDLE;
  endproperty
  a_nack_bad: assert property (p_nack_bad)
    else $error("wrong address acknowledged");
  property p_idle;
    s.st == ST_IDLE && !startDet |=> s.st == ST_IDLE && !s.sdaOe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("bus activity taken without start");
  property p_stop_idle;
    stopDet |=> s.st == ST_IDLE ##1 !s.sdaOe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop did not return to standby");
  property p_read_end;
    s.st == ST_RXACK && sclRise && sdaS && quiet
      |=> s.st == ST_IDLE && !s.sdaOe;
  endproperty
  a_read_end: assert property (p_read_end)
    else $error("read continued without acknowledge");
  property p_lvr;
    lvrS |=> s.st == ST_IDLE && !s.sdaOe;
  endproperty
  a_lvr: assert property (p_lvr)
    else $error("transfer survived low supply");
  property p_rst_addr;
    $rose(nrst) |-> s.addr == 16'h0000;
  endproperty
  a_rst_addr: assert property (p_rst_addr)
    else $error("address counter not zero after reset");
  property p_commit;
    stopDet && !s.busy && !s.rw && s.dataSeen && !prot
      |=> s.busy [*2];
  endproperty
  a_commit: assert property (p_commit)
    else $error("write cycle not started after stop");
  property p_busy_quiet;
    s.busy |-> !s.sdaOe && (s.st == ST_IDLE);
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("bus answered during write cycle");
  property p_prot;
    stopDet && !s.busy && prot |=> !s.busy;
  endproperty
  a_prot: assert property (p_prot)
    else $error("protected write started a write cycle");
  property p_short;
    stopDet && !s.dataSeen && !s.busy |=> !s.busy;
  endproperty
  a_short: assert property (p_short)
    else $error("incomplete write was committed");
  property p_wrap;
    s.st == ST_ACK && sclFall && s.ackData && quiet
      |=> s.addr[15:4] == $past(s.addr[15:4])
        && s.addr[3:0] != $past(s.addr[3:0]);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("page pointer left its page");
  property p_poll;
    s.busy && startDet |=> s.st == ST_IDLE ##8 !s.sdaOe;
  endproperty
  a_poll: assert property (p_poll)
    else $error("start accepted during write cycle");
  property p_sync;
    s.syncB == $past(s.syncA);
  endproperty
  a_sync: assert property (p_sync)
    else $error("second sync stage skipped");
  c_commit: cover property (stopDet && !s.busy && !s.rw && s.dataSeen);
  c_read_ack: cover property (s.st == ST_RXACK && sclRise && !sdaS);
endmodule

// ---- dv/two_wire_master.sv ----
// two-wire bus master model: open-drain data, clock idles high
// assumes the bench forms the data wire with a pull-up
`timescale 1ns/10ps
module two_wire_master (
  // bus
  output logic scl,
  output logic sdaPull,
  input wire logic sdaWire
);
  initial begin
    scl = 1'b1;
    sdaPull = 1'b0;
  end
  // one bit: low 500 ns, data set 200 ns in, high 300 ns
  task automatic bitX(input logic b, output logic seen);
    scl = 1'b0;
    #200;
    sdaPull = !b;
    #300;
    scl = 1'b1;
    #300;
    seen = sdaWire;
  endtask
  // start or repeated start
  task automatic start();
    logic s;
    bitX(1'b1, s);
    sdaPull = 1'b1;
    #300;
  endtask
  task automatic stop();
    logic s;
    bitX(1'b0, s);
    sdaPull = 1'b0;
    #300;
  endtask
  // byte msb first, then the acknowledge bit
  task automatic byteX(input logic [7:0] d, input logic ackBit,
    output logic [7:0] q, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitX(d[i], s);
      q[i] = s;
    end
    bitX(ackBit, s);
    acked = !s;
  endtask
endmodule

// ---- dv/i2c_slave_with_watchdog_tb_top.sv ----
// bench for the two-wire slave with watchdog and reset output
// assumes short timer parameters and a pull-up on the data wire
`timescale 1ns/10ps
module i2c_slave_with_watchdog_tb_top;
  localparam int WA = 200;
  localparam int WB = 300;
  localparam int WC = 400;
  localparam int RST = 100;
  // slave byte and whether it is acknowledged
  typedef struct packed {
    logic [7:0] sa;
    logic ack;
  } row_t;
  row_t rows[6] = '{'{8'hae, 1'b1}, '{8'hde, 1'b1}, '{8'hac, 1'b0},
    '{8'hda, 1'b0}, '{8'h5e, 1'b0}, '{8'hee, 1'b0}};
  int per[3] = '{WA, WB, WC};
  logic [7:0] unl[2] = '{8'h02, 8'h06};
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] sel = 2'h3;
  logic lowV = 1'b0;
  logic bat = 1'b0;
  logic prot = 1'b0;
  logic scl, mPull, sdaOut, sdaOe, rstOutN, ak;
  logic [7:0] q;
  int errorCnt = 0;
  int totalChecks = 0;
  int n;
  wire logic sdaWire = !mPull && !(sdaOe && !sdaOut);

  always #50 clk_sys = ~clk_sys;

  two_wire_master mst_u (
    .scl(scl),
    .sdaPull(mPull),
    .sdaWire(sdaWire)
  );
  i2c_slave_with_watchdog #(
    .WDT_C250(WA), .WDT_C750(WB), .WDT_C1750(WC), .RST_CYC(RST),
    .WR_CYC(400)
  ) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .watchdogPeriodSelHi(sel[1]),
    .watchdogPeriodSelLo(sel[0]), .lowVoltageReset(lowV),
    .batteryMode(bat), .blockProtect(prot), .rstOutN(rstOutN)
  );

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    totalChecks++;
    if (s !== e) begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clk_sys);
  endtask
  task automatic waitRst(input logic v, input int lim, output int c);
    c = 0;
    while (rstOutN !== v) begin
      cyc(1);
      c++;
      if (c > lim) begin
        errorCnt++;
        results();
      end
    end
  endtask
  task automatic sb(input logic [7:0] d, input logic e);
    mst_u.byteX(d, 1'b1, q, ak);
    check(ak, e);
  endtask
  task automatic wrHdr(input logic [15:0] a);
    mst_u.start();
    sb(8'hae, 1'b1);
    sb(a[15:8], 1'b1);
    sb(a[7:0], 1'b1);
  endtask
  // dummy write with slave byte aeh, then read with afh
  task automatic rdHdr(input logic [15:0] a);
    wrHdr(a);
    mst_u.start();
    sb(8'haf, 1'b1);
  endtask
  task automatic ccrHdr(input logic [15:0] a);
    mst_u.start();
    sb(8'hde, 1'b1);
    sb(a[15:8], 1'b1);
    sb(a[7:0], 1'b1);
  endtask
  // poll with the array slave byte until acknowledged, bounded
  task automatic poll();
    n = 0;
    do begin
      mst_u.start();
      mst_u.byteX(8'hae, 1'b1, q, ak);
      mst_u.stop();
      n++;
    end while (!ak && n < 12);
  endtask
  task automatic kick();
    mst_u.start();
    mst_u.stop();
  endtask

  initial begin
    cyc(6);
    check(rstOutN, 1'b0);
    check(sdaOe, 1'b0);
    check(sdaOut, 1'b0);
    nrst = 1'b1;
    waitRst(1'b1, RST + 20, n);
    check(n inside {[RST - 5:RST + 10]}, 1'b1);
    done("reset");
    foreach (rows[i]) begin
      mst_u.start();
      mst_u.byteX(rows[i].sa, 1'b1, q, ak);
      check(ak, rows[i].ack);
      mst_u.stop();
    end
    done("address");
    // 17 bytes from 2eh: wraps in page, last byte lands on 2eh
    wrHdr(16'h002e);
    for (int i = 0; i < 17; i++) begin
      sb(8'h40 + i[7:0], 1'b1);
    end
    mst_u.stop();
    poll();
    check(ak, 1'b1);
    check(n > 3, 1'b1);
    mst_u.start();
    sb(8'haf, 1'b1);
    mst_u.byteX(8'hff, 1'b1, q, ak);
    check(q, 8'h41);
    mst_u.stop();
    rdHdr(16'h0020);
    for (int k = 0; k < 16; k++) begin
      mst_u.byteX(8'hff, k == 15, q, ak);
      check(q, k == 14 ? 8'h50 : k == 15 ? 8'h41 : 8'h42 + k[7:0]);
    end
    mst_u.stop();
    done("page");
    wrHdr(16'h0020);
    repeat (4) mst_u.bitX(1'b1, ak);
    mst_u.stop();
    mst_u.start();
    sb(8'hae, 1'b1);
    mst_u.stop();
    rdHdr(16'h0020);
    mst_u.byteX(8'hff, 1'b1, q, ak);
    check(q, 8'h42);
    mst_u.stop();
    prot = 1'b1;
    wrHdr(16'h0100);
    sb(8'h5a, 1'b1);
    mst_u.stop();
    mst_u.start();
    sb(8'hae, 1'b1);
    mst_u.stop();
    prot = 1'b0;
    done("abort");
    // unlock with two status writes, then one full clock page
    foreach (unl[i]) begin
      ccrHdr(16'h002f);
      sb(unl[i], 1'b1);
      mst_u.stop();
      poll();
      check(ak, 1'b1);
    end
    ccrHdr(16'h0030);
    for (int i = 0; i < 8; i++) begin
      sb(8'h60 + i[7:0], 1'b1);
    end
    mst_u.stop();
    poll();
    check(ak, 1'b1);
    ccrHdr(16'h002f);
    mst_u.start();
    sb(8'hdf, 1'b1);
    for (int k = 0; k < 9; k++) begin
      mst_u.byteX(8'hff, k == 8, q, ak);
      check(q, k == 0 ? 8'h06 : 8'h5f + k[7:0]);
    end
    mst_u.stop();
    done("control");
    sel = 2'h2;
    cyc(10);
    repeat (4) begin
      kick();
      cyc(150);
      check(rstOutN, 1'b1);
    end
    for (int s = 0; s < 3; s++) begin
      sel = 2'h2 - s[1:0];
      kick();
      waitRst(1'b0, per[s] + 20, n);
      check(n inside {[per[s] - 20:per[s] + 5]}, 1'b1);
      kick();
      waitRst(1'b1, RST + 20, n);
      check((n + 22) inside {[RST - 5:RST + 5]}, 1'b1);
    end
    sel = 2'h3;
    cyc(WC * 2);
    check(rstOutN, 1'b1);
    bat = 1'b1;
    sel = 2'h2;
    cyc(WA * 2);
    check(rstOutN, 1'b1);
    sel = 2'h3;
    bat = 1'b0;
    done("watchdog");
    lowV = 1'b1;
    cyc(5);
    check(rstOutN, 1'b0);
    mst_u.start();
    sb(8'hae, 1'b0);
    mst_u.stop();
    lowV = 1'b0;
    waitRst(1'b1, RST + 20, n);
    check(n inside {[RST - 5:RST + 10]}, 1'b1);
    bat = 1'b1;
    lowV = 1'b1;
    cyc(10);
    lowV = 1'b0;
    cyc(RST * 3);
    check(rstOutN, 1'b0);
    bat = 1'b0;
    waitRst(1'b1, RST + 20, n);
    check(n inside {[RST - 5:RST + 10]}, 1'b1);
    done("supply");
    results();
  end
endmodule
